/* cpl_frame_pkg.sv */
`default_nettype none
package cpl_frame_pkg;

  // sideband bit positions on the completion sideband bus
  localparam int SB_W = 75;
  localparam int SB_FIRST_START = 32;
  localparam int SB_SECOND_START = 33;
  localparam int SB_FIRST_END_LO = 34;
  localparam int SB_SECOND_END_LO = 38;
  localparam int SB_ABORT = 42;
  localparam int SB_PARITY_LO = 43;
  localparam int PARITY_W = 32;
  localparam int STRADDLE_W = 256;

  // smallest legal dword offset of a second straddled end
  localparam logic [2:0] SECOND_END_MIN_OFS = 3'h6;

  // register byte offsets
  localparam logic [3:0] CTRL_OFS = 4'h0;
  localparam logic [3:0] STATUS_OFS = 4'h4;
  localparam logic [3:0] TLP_COUNT_OFS = 4'h8;
  localparam logic [3:0] ABORT_COUNT_OFS = 4'hc;

  // control field positions and reset values
  localparam int CTRL_STRADDLE_BIT = 0;
  localparam int CTRL_ENDPOINT_BIT = 1;
  localparam logic [1:0] CTRL_RESET = 2'h0;
  localparam logic [15:0] COUNT_RESET = 16'h0000;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // per-beat framing offered by the completion payload reader
  typedef struct packed {
    logic first_start;
    logic second_start;
    logic [3:0] first_end;
    logic [3:0] second_end;
    logic last;
    logic has_payload;
    logic read_error;
  } beat_info_t;

  // framing fields as they leave on the sideband bus
  typedef struct packed {
    logic abort;
    logic [3:0] second_end;
    logic [3:0] first_end;
    logic second_start;
    logic first_start;
  } frame_fields_t;

endpackage
`default_nettype wire

/* cpl_rx_model.sv */
`timescale 1ns/1ps
`default_nettype none
module cpl_rx_model (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic completion_valid_out,
  output logic completion_ready_in,
  input wire logic [255:0] completion_data_bus,
  input wire logic [cpl_frame_pkg::SB_W-1:0] completion_sideband_bus,
  input wire logic completion_packet_end_out,
  output logic [15:0] seen_count,
  output logic [255:0] seen_data,
  output logic [cpl_frame_pkg::SB_W-1:0] seen_sb,
  output logic seen_end,
  output logic [15:0] hold_errors,
  output logic [15:0] good_count,
  output logic [15:0] drop_count
);
  logic [1:0] pace_reg;
  logic stall_reg;
  logic [255:0] data_reg;
  logic [cpl_frame_pkg::SB_W-1:0] sb_reg;
  // TLP ends from end markers only, start flags and end offsets unused
  wire first_ended = completion_packet_end_out
    || completion_sideband_bus[cpl_frame_pkg::SB_FIRST_END_LO];
  wire [1:0] ends = {1'b0, first_ended}
    + {1'b0, completion_sideband_bus[cpl_frame_pkg::SB_SECOND_END_LO]};
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pace_reg <= 2'h0;
      completion_ready_in <= 1'b0;
      stall_reg <= 1'b0;
      seen_count <= 16'h0000;
      hold_errors <= 16'h0000;
      good_count <= 16'h0000;
      drop_count <= 16'h0000;
    end else begin
      pace_reg <= pace_reg + 2'h1;
      // paced ready, stalls one cycle in four
      completion_ready_in <= (pace_reg != 2'h1);
      stall_reg <= completion_valid_out && !completion_ready_in;
      data_reg <= completion_data_bus;
      sb_reg <= completion_sideband_bus;
      if (stall_reg && (!completion_valid_out || data_reg !== completion_data_bus ||
          sb_reg !== completion_sideband_bus)) begin
        hold_errors <= hold_errors + 16'h0001;
      end
      // fields taken only on a transfer
      if (completion_valid_out && completion_ready_in) begin
        seen_count <= seen_count + 16'h0001;
        seen_data <= completion_data_bus;
        seen_sb <= completion_sideband_bus;
        seen_end <= completion_packet_end_out;
        // aborted TLP dropped whole, never counted as good
        if (completion_sideband_bus[cpl_frame_pkg::SB_ABORT]) begin
          drop_count <= drop_count + 16'h0001;
        end else begin
          good_count <= good_count + {14'h0000, ends};
        end
      end
    end
  end
endmodule // cpl_rx_model
`default_nettype wire

/* cpl_stream_framer.sv */
// How it works
// R01 - first-start flag in bit 32 on each packet's first beat
// R02 - without straddle, one start per beat, second-start flag held zero
// R03 - straddled first start sits at lane 0, or lane 16 if prior TLP continues
// R04 - second start at lane 16 only when first end set same beat
// R05 - straddle: bits 37:34 first-end, bit 0 end, bits 3:1 dword offset
// R06 - bits 41:38 second-end, reserved otherwise, offset 6 or 7 only
// R07 - second end implies first end and second start in same beat
// R08 - payload read error raises abort bit 42 in TLP's final beat
// R09 - receiver drops the whole TLP flagged by abort
// R10 - no abort without payload; abort only with first end high
// R11 - no second start in a beat carrying abort
// R12 - endpoint mode reports payload read errors for advanced error reporting
// R13 - bits 74:43 give odd parity per data byte
// R14 - parity bits above the bus bytes held zero for narrow widths
// R15 - 256-bit straddle may carry two TLPs per beat, not stream packets
// R16 - receiver derives second TLP last byte from address, length, byte enables
// R17 - receiver may ignore first-start flag without straddle
// R18 - beat moves only when valid and ready both high
// R19 - stalled beat keeps data, sideband and valid steady until ready
// R20 - straddle on 256 bits keeps packet-end output at zero
// R21 - receiver samples sideband fields only on transferred beats
//
// The register offsets and the AXI4-Lite register port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module cpl_stream_framer #(
  parameter int DATA_W = 256
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic beat_valid,
  output logic beat_ready,
  input wire logic [DATA_W-1:0] beat_data,
  input wire cpl_frame_pkg::beat_info_t beat_info,
  output logic completion_valid_out,
  input wire logic completion_ready_in,
  output logic [DATA_W-1:0] completion_data_bus,
  output logic [cpl_frame_pkg::SB_W-1:0] completion_sideband_bus,
  output logic completion_packet_end_out,
  output logic error_report_out,
  input wire logic [3:0] s_axil_awaddr,
  input wire logic s_axil_awvalid,
  output logic s_axil_awready,
  input wire logic [31:0] s_axil_wdata,
  input wire logic [3:0] s_axil_wstrb,
  input wire logic s_axil_wvalid,
  output logic s_axil_wready,
  output logic [1:0] s_axil_bresp,
  output logic s_axil_bvalid,
  input wire logic s_axil_bready,
  input wire logic [3:0] s_axil_araddr,
  input wire logic s_axil_arvalid,
  output logic s_axil_arready,
  output logic [31:0] s_axil_rdata,
  output logic [1:0] s_axil_rresp,
  output logic s_axil_rvalid,
  input wire logic s_axil_rready
);

  localparam int BYTES = DATA_W / 8;

  logic [1:0] ctrl_reg;
  logic open_reg;
  logic [15:0] tlp_count_reg;
  logic [15:0] abort_count_reg;
  logic [3:0] aw_addr_reg;
  logic [31:0] w_data_reg;
  logic [3:0] w_strb_reg;
  logic [cpl_frame_pkg::PARITY_W-1:0] parity_next;
  cpl_frame_pkg::frame_fields_t fields_next;
  cpl_frame_pkg::frame_fields_t fields_out;

  wire straddle_on = ctrl_reg[cpl_frame_pkg::CTRL_STRADDLE_BIT] && (DATA_W == cpl_frame_pkg::STRADDLE_W);
  wire endpoint_on = ctrl_reg[cpl_frame_pkg::CTRL_ENDPOINT_BIT];
  wire take_beat = beat_valid && beat_ready;
  // R18 transfer condition
  wire out_xfer = completion_valid_out && completion_ready_in;

  // R05 end of first TLP in the beat
  wire first_end_hit = straddle_on ? beat_info.first_end[0] : beat_info.last;
  // R08 abort on final payload beat
  // R10 payload and first end needed
  wire abort_next = beat_info.read_error && beat_info.has_payload && first_end_hit;
  // R04 second start needs first end
  // R11 no second start with abort
  // R02 second start zero without straddle
  wire second_start_next = straddle_on && beat_info.second_start && beat_info.first_end[0]
    && !abort_next;
  // R06 second end offset 6 or 7
  // R07 second end tied to first end and second start
  wire second_end_ok = second_start_next && beat_info.second_end[0]
    && (beat_info.second_end[3:1] >= cpl_frame_pkg::SECOND_END_MIN_OFS);
  // R20 packet end low under straddle
  wire packet_end_next = !straddle_on && beat_info.last;

  // R01 first start passes on
  assign fields_next.first_start = beat_info.first_start;
  assign fields_next.second_start = second_start_next;
  // R05 first end only in straddle
  assign fields_next.first_end = straddle_on ? beat_info.first_end : 4'h0;
  assign fields_next.second_end = second_end_ok ? beat_info.second_end : 4'h0;
  assign fields_next.abort = abort_next;

  // R13 odd parity per byte
  // R14 unused parity bits zero
  genvar gi;
  generate
    for (gi = 0; gi < cpl_frame_pkg::PARITY_W; gi++) begin : g_par
      if (gi < BYTES) begin : g_used
        assign parity_next[gi] = ~^beat_data[gi*8 +: 8];
      end else begin : g_zero
        assign parity_next[gi] = 1'b0;
      end
    end
  endgenerate

  assign fields_out = completion_sideband_bus[cpl_frame_pkg::SB_PARITY_LO-1:cpl_frame_pkg::SB_FIRST_START];

  // R19 output slot holds until taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      completion_valid_out <= 1'b0;
      beat_ready <= 1'b0;
      completion_data_bus <= '0;
      completion_sideband_bus <= '0;
      completion_packet_end_out <= 1'b0;
    end else if (take_beat) begin
      completion_valid_out <= 1'b1;
      beat_ready <= 1'b0;
      completion_data_bus <= beat_data;
      completion_sideband_bus <= {parity_next, fields_next, 32'h0000_0000};
      completion_packet_end_out <= packet_end_next;
    end else if (out_xfer || !completion_valid_out) begin
      completion_valid_out <= 1'b0;
      beat_ready <= 1'b1;
    end
  end

  // R03 tracks a TLP still open across beats
  // R15 up to two starts counted per straddled beat
  wire open_after = fields_out.second_start ? !fields_out.second_end[0]
    : fields_out.first_start ? !(fields_out.first_end[0] && !open_reg)
    : fields_out.first_end[0] ? 1'b0 : open_reg;
  wire [1:0] starts = {1'b0, fields_out.first_start} + {1'b0, fields_out.second_start};

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      open_reg <= 1'b0;
      tlp_count_reg <= cpl_frame_pkg::COUNT_RESET;
      abort_count_reg <= cpl_frame_pkg::COUNT_RESET;
      error_report_out <= 1'b0;
    end else begin
      // R12 endpoint error report pulse
      error_report_out <= out_xfer && fields_out.abort && endpoint_on;
      if (out_xfer) begin
        open_reg <= straddle_on ? open_after : !completion_packet_end_out;
        tlp_count_reg <= tlp_count_reg + {14'h0000, starts};
        abort_count_reg <= abort_count_reg + {15'h0000, fields_out.abort};
      end
    end
  end

  // register bus slave
  wire aw_take = s_axil_awvalid && s_axil_awready;
  wire w_take = s_axil_wvalid && s_axil_wready;
  wire commit = !s_axil_awready && !s_axil_wready && !s_axil_bvalid;
  wire wr_ctrl = aw_addr_reg == cpl_frame_pkg::CTRL_OFS;
  wire wr_known = wr_ctrl || aw_addr_reg == cpl_frame_pkg::STATUS_OFS
    || aw_addr_reg == cpl_frame_pkg::TLP_COUNT_OFS || aw_addr_reg == cpl_frame_pkg::ABORT_COUNT_OFS;
  wire ar_take = s_axil_arvalid && s_axil_arready;
  wire rd_ctrl = s_axil_araddr == cpl_frame_pkg::CTRL_OFS;
  wire rd_status = s_axil_araddr == cpl_frame_pkg::STATUS_OFS;
  wire rd_tlp = s_axil_araddr == cpl_frame_pkg::TLP_COUNT_OFS;
  wire rd_abort = s_axil_araddr == cpl_frame_pkg::ABORT_COUNT_OFS;
  wire rd_known = rd_ctrl || rd_status || rd_tlp || rd_abort;
  wire [31:0] rd_value = rd_ctrl ? {30'h0000_0000, ctrl_reg}
    : rd_status ? {30'h0000_0000, completion_valid_out, open_reg}
    : rd_tlp ? {16'h0000, tlp_count_reg}
    : rd_abort ? {16'h0000, abort_count_reg} : 32'h0000_0000;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axil_awready <= 1'b1;
      s_axil_wready <= 1'b1;
      s_axil_bvalid <= 1'b0;
      s_axil_bresp <= cpl_frame_pkg::RESP_OKAY;
      aw_addr_reg <= 4'h0;
      w_data_reg <= 32'h0000_0000;
      w_strb_reg <= 4'h0;
      ctrl_reg <= cpl_frame_pkg::CTRL_RESET;
    end else begin
      if (aw_take) begin
        s_axil_awready <= 1'b0;
        aw_addr_reg <= s_axil_awaddr;
      end
      if (w_take) begin
        s_axil_wready <= 1'b0;
        w_data_reg <= s_axil_wdata;
        w_strb_reg <= s_axil_wstrb;
      end
      if (commit) begin
        s_axil_bvalid <= 1'b1;
        s_axil_bresp <= wr_known ? cpl_frame_pkg::RESP_OKAY : cpl_frame_pkg::RESP_SLVERR;
        if (wr_ctrl && w_strb_reg[0]) begin
          ctrl_reg <= w_data_reg[1:0];
        end
      end
      if (s_axil_bvalid && s_axil_bready) begin
        s_axil_bvalid <= 1'b0;
        s_axil_awready <= 1'b1;
        s_axil_wready <= 1'b1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axil_arready <= 1'b1;
      s_axil_rvalid <= 1'b0;
      s_axil_rdata <= 32'h0000_0000;
      s_axil_rresp <= cpl_frame_pkg::RESP_OKAY;
    end else if (ar_take) begin
      s_axil_arready <= 1'b0;
      s_axil_rvalid <= 1'b1;
      s_axil_rdata <= rd_value;
      s_axil_rresp <= rd_known ? cpl_frame_pkg::RESP_OKAY : cpl_frame_pkg::RESP_SLVERR;
    end else if (s_axil_rvalid && s_axil_rready) begin
      s_axil_rvalid <= 1'b0;
      s_axil_arready <= 1'b1;
    end
  end

  // checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence stalled_beat;
    completion_valid_out && !completion_ready_in;
  endsequence

  chk_stall_holds: assert property (stalled_beat |=> completion_valid_out // R19
    && $stable(completion_data_bus) && $stable(completion_sideband_bus))
    else $error("stalled beat changed");
  chk_second_start_mode: assert property (!straddle_on |-> // R02
    !fields_next.second_start && !fields_next.second_end[0])
    else $error("second start outside straddle");
  chk_second_start_end: assert property (completion_sideband_bus[cpl_frame_pkg::SB_SECOND_START] // R04
    |-> completion_sideband_bus[cpl_frame_pkg::SB_FIRST_END_LO])
    else $error("second start without first end");
  chk_second_end_ofs: assert property (completion_sideband_bus[cpl_frame_pkg::SB_SECOND_END_LO] // R06
    |-> completion_sideband_bus[cpl_frame_pkg::SB_SECOND_END_LO+3:cpl_frame_pkg::SB_SECOND_END_LO+1] >= 3'h6)
    else $error("second end offset illegal");
  chk_second_end_pair: assert property (fields_out.second_end[0] // R07
    |-> fields_out.first_end[0] && fields_out.second_start)
    else $error("second end without first end and second start");
  chk_abort_payload: assert property (take_beat && fields_next.abort // R10
    |=> (straddle_on ? fields_out.first_end[0] : completion_packet_end_out))
    else $error("abort off the final beat");
  chk_abort_error: assert property (take_beat && beat_info.read_error && beat_info.has_payload // R08
    && first_end_hit |=> completion_sideband_bus[cpl_frame_pkg::SB_ABORT])
    else $error("read error not flagged");
  chk_abort_nosecond: assert property (fields_out.abort |-> !fields_out.second_start) // R11
    else $error("second start with abort");
  chk_error_report: assert property (out_xfer && fields_out.abort && endpoint_on // R12
    |=> error_report_out) else $error("error report missing");
  chk_parity_odd: assert property (take_beat |=> // R13
    ^{completion_data_bus[7:0], completion_sideband_bus[cpl_frame_pkg::SB_PARITY_LO]})
    else $error("parity not odd");
  chk_packet_end_low: assert property (straddle_on && $stable(ctrl_reg) // R20
    && $past(take_beat) |-> !completion_packet_end_out)
    else $error("packet end under straddle");

endmodule // cpl_stream_framer
`default_nettype wire

/* test_completion_stream_sideband_framing.sv */
`timescale 1ns/1ps
`default_nettype none
module test_completion_stream_sideband_framing;
  logic aclk = 1'b0, aresetn = 1'b0, beat_valid = 1'b0, beat_ready;
  logic [255:0] beat_data = '0, completion_data_bus, seen_data;
  cpl_frame_pkg::beat_info_t beat_info = '0;
  logic completion_valid_out, completion_ready_in, completion_packet_end_out, error_report_out;
  logic [74:0] completion_sideband_bus, seen_sb;
  logic seen_end;
  logic [15:0] seen_count, hold_errors, good_count, drop_count;
  logic [3:0] s_axil_awaddr = 4'h0, s_axil_wstrb = 4'hf, s_axil_araddr = 4'h0;
  logic s_axil_awvalid = 1'b0, s_axil_wvalid = 1'b0, s_axil_bready = 1'b0;
  logic s_axil_arvalid = 1'b0, s_axil_rready = 1'b0;
  logic s_axil_awready, s_axil_wready, s_axil_bvalid, s_axil_arready, s_axil_rvalid;
  logic [31:0] s_axil_wdata = 32'h0000_0000, s_axil_rdata, rd;
  logic [1:0] s_axil_bresp, s_axil_rresp, rr;
  int bad_count = 0, n_compared = 0, err_pulses = 0, beat_k = 0;
  always #25 aclk = ~aclk;
  cpl_stream_framer u_cpl_stream_framer (.aclk(aclk), .aresetn(aresetn), .beat_valid(beat_valid),
    .beat_ready(beat_ready), .beat_data(beat_data), .beat_info(beat_info),
    .completion_valid_out(completion_valid_out), .completion_ready_in(completion_ready_in),
    .completion_data_bus(completion_data_bus), .completion_sideband_bus(completion_sideband_bus),
    .completion_packet_end_out(completion_packet_end_out), .error_report_out(error_report_out),
    .s_axil_awaddr(s_axil_awaddr), .s_axil_awvalid(s_axil_awvalid), .s_axil_awready(s_axil_awready),
    .s_axil_wdata(s_axil_wdata), .s_axil_wstrb(s_axil_wstrb), .s_axil_wvalid(s_axil_wvalid),
    .s_axil_wready(s_axil_wready), .s_axil_bresp(s_axil_bresp), .s_axil_bvalid(s_axil_bvalid),
    .s_axil_bready(s_axil_bready), .s_axil_araddr(s_axil_araddr), .s_axil_arvalid(s_axil_arvalid),
    .s_axil_arready(s_axil_arready), .s_axil_rdata(s_axil_rdata), .s_axil_rresp(s_axil_rresp),
    .s_axil_rvalid(s_axil_rvalid), .s_axil_rready(s_axil_rready));
  cpl_rx_model u_cpl_rx_model (.aclk(aclk), .aresetn(aresetn),
    .completion_valid_out(completion_valid_out), .completion_ready_in(completion_ready_in),
    .completion_data_bus(completion_data_bus), .completion_sideband_bus(completion_sideband_bus),
    .completion_packet_end_out(completion_packet_end_out), .seen_count(seen_count),
    .seen_data(seen_data), .seen_sb(seen_sb), .seen_end(seen_end), .hold_errors(hold_errors),
    .good_count(good_count), .drop_count(drop_count));
  always @(posedge aclk) if (error_report_out === 1'b1) err_pulses++;
  task automatic check(input string what, input logic [74:0] seen, input logic [74:0] exp);
    n_compared++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  function automatic logic [31:0] odd_par(input logic [255:0] d);
    logic [31:0] p;
    for (int i = 0; i < 32; i++) p[i] = ~^d[8*i +: 8];
    return p;
  endfunction
  task automatic axi_write(input logic [3:0] a, input logic [31:0] d);
    s_axil_awaddr <= a;
    s_axil_wdata <= d;
    s_axil_awvalid <= 1'b1;
    s_axil_wvalid <= 1'b1;
    s_axil_bready <= 1'b1;
    while (s_axil_bvalid !== 1'b1) begin
      @(posedge aclk);
      if (s_axil_awready === 1'b1) s_axil_awvalid <= 1'b0;
      if (s_axil_wready === 1'b1) s_axil_wvalid <= 1'b0;
    end
    s_axil_bready <= 1'b0;
    check("bresp", s_axil_bresp, cpl_frame_pkg::RESP_OKAY);
    @(posedge aclk);
  endtask
  task automatic axi_read(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
    s_axil_araddr <= a;
    s_axil_arvalid <= 1'b1;
    s_axil_rready <= 1'b1;
    while (s_axil_rvalid !== 1'b1) begin
      @(posedge aclk);
      if (s_axil_arready === 1'b1) s_axil_arvalid <= 1'b0;
    end
    d = s_axil_rdata;
    r = s_axil_rresp;
    s_axil_rready <= 1'b0;
    @(posedge aclk);
  endtask
  task automatic send_beat(input logic fs, ss, input logic [3:0] fe, se, input logic lst, hp, re,
                           input logic e_ss, input logic [3:0] e_fe, e_se, input logic e_ab, e_end);
    logic [255:0] d;
    logic [15:0] c0;
    d = {8{32'h1234_5678 + beat_k}};
    beat_k++;
    c0 = seen_count;
    beat_valid <= 1'b1;
    beat_data <= d;
    beat_info <= {fs, ss, fe, se, lst, hp, re};
    do begin
      @(posedge aclk);
    end while (beat_ready !== 1'b1);
    beat_valid <= 1'b0;
    while (seen_count === c0) begin
      @(posedge aclk);
    end
    check("data", seen_data[74:0], d[74:0]);
    check("data high", seen_data[255:181], d[255:181]);
    check("sideband", seen_sb, {odd_par(d), e_ab, e_se, e_fe, e_ss, fs, 32'h0000_0000});
    check("packet end", seen_end, e_end);
  endtask
  task automatic stop_test();
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    #(50 * 20000);
    bad_count++;
    stop_test();
  end
  initial begin
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    send_beat(1'h1, 1'h1, 4'h7, 4'hd, 1'h1, 1'h1, 1'h0, 1'h0, 4'h0, 4'h0, 1'h0, 1'h1);
    send_beat(1'h1, 1'h0, 4'h0, 4'h0, 1'h0, 1'h1, 1'h0, 1'h0, 4'h0, 4'h0, 1'h0, 1'h0);
    send_beat(1'h0, 1'h0, 4'h0, 4'h0, 1'h1, 1'h1, 1'h1, 1'h0, 4'h0, 4'h0, 1'h1, 1'h1);
    $display("test plain framing done");
    axi_write(cpl_frame_pkg::CTRL_OFS, 32'h0000_0001);
    send_beat(1'h1, 1'h1, 4'h7, 4'hd, 1'h1, 1'h1, 1'h0, 1'h1, 4'h7, 4'hd, 1'h0, 1'h0);
    send_beat(1'h1, 1'h1, 4'h7, 4'h5, 1'h1, 1'h1, 1'h0, 1'h1, 4'h7, 4'h0, 1'h0, 1'h0);
    send_beat(1'h0, 1'h1, 4'h6, 4'hf, 1'h0, 1'h1, 1'h0, 1'h0, 4'h6, 4'h0, 1'h0, 1'h0);
    send_beat(1'h0, 1'h1, 4'h9, 4'hd, 1'h1, 1'h1, 1'h1, 1'h0, 4'h9, 4'h0, 1'h1, 1'h0);
    send_beat(1'h1, 1'h0, 4'h5, 4'h0, 1'h1, 1'h0, 1'h1, 1'h0, 4'h5, 4'h0, 1'h0, 1'h0);
    send_beat(1'h1, 1'h0, 4'h6, 4'h0, 1'h0, 1'h1, 1'h1, 1'h0, 4'h6, 4'h0, 1'h0, 1'h0);
    check("error pulses", err_pulses, 0);
    $display("test straddle framing done");
    axi_write(cpl_frame_pkg::CTRL_OFS, 32'h0000_0003);
    send_beat(1'h0, 1'h0, 4'hf, 4'h0, 1'h1, 1'h1, 1'h1, 1'h0, 4'hf, 4'h0, 1'h1, 1'h0);
    repeat (3) @(posedge aclk);
    check("error pulses", err_pulses, 1);
    axi_read(cpl_frame_pkg::CTRL_OFS, rd, rr);
    check("ctrl", rd, 32'h0000_0003);
    axi_read(cpl_frame_pkg::ABORT_COUNT_OFS, rd, rr);
    check("abort count", rd, 32'h0000_0003);
    check("abort resp", rr, cpl_frame_pkg::RESP_OKAY);
    axi_read(cpl_frame_pkg::TLP_COUNT_OFS, rd, rr);
    check("tlp starts", rd, 32'h0000_0008);
    check("hold errors", hold_errors, 16'h0000);
    check("good tlps", good_count, 16'h0005);
    check("dropped tlps", drop_count, 16'h0003);
    $display("test endpoint report done");
    stop_test();
  end
endmodule // test_completion_stream_sideband_framing
`default_nettype wire
